// ===== verilog/loopback_tone_consts.vh
// Purpose: Constants for the loopback tone detect and control block
// Assumes: core_clk at 20 MHz; tone and timeout times counted in 1 ms ticks
// Notes:   Definitions only
`ifndef LOOPBACK_TONE_CONSTS_VH
`define LOOPBACK_TONE_CONSTS_VH

// ----------------------------------------------------------------
// Clock and tick
// ----------------------------------------------------------------
`define CLK_HZ              20000000
`define TICK_MS             1
`define MS_TICK_CYCLES      (`CLK_HZ / 1000 * `TICK_MS)

// ----------------------------------------------------------------
// Three-level select codes
// ----------------------------------------------------------------
`define SEL_LOW             2'h0
`define SEL_REF             2'h1
`define SEL_HIGH            2'h2

// ----------------------------------------------------------------
// Tone frequency bands, Hz
// ----------------------------------------------------------------
`define ACCEPT_LO_HZ        12'hA8D
`define ACCEPT_HI_HZ        12'hAA5
`define REJECT_LO_HZ        12'hA79
`define REJECT_HI_HZ        12'hAB9

// ----------------------------------------------------------------
// Levels, dBm and dB, signed 9 bit
// ----------------------------------------------------------------
`define LEVEL_MIN_DBM       (-9'sd33)
`define LEVEL_MAX_DBM       (9'sd0)
`define LEVEL_REJECT_DBM    (-9'sd38)
`define GUARD_MIN_DB        (9'sd9)
`define GUARD_MAX_DB        (9'sd15)
`define GUARD_MARGIN_DB     (9'sd12)

// ----------------------------------------------------------------
// Tone timing, ms
// ----------------------------------------------------------------
`define DETECT_MAX_MS       60
`define ACT_QUAL_MS         11'h7D0
`define ACT_REJECT_MS       11'h76C
`define REST_QUAL_MS        11'h3E8
`define GAP_EARLY_MS        8'h14
`define GAP_LATE_MS         8'hC8

// ----------------------------------------------------------------
// Fail-safe timeout, ms (1.5, 4.0, 20.0 minutes)
// ----------------------------------------------------------------
`define TIMEOUT_SHORT_MS    21'h015F90
`define TIMEOUT_MID_MS      21'h03A980
`define TIMEOUT_LONG_MS     21'h124F80

// ----------------------------------------------------------------
// Internal clock rates, Hz, and half periods in core_clk cycles
// ----------------------------------------------------------------
`define ICLK_TEST_HZ        4000
`define ICLK_REF_HZ         31250
`define ICLK_LOW_SHORT_HZ   16000
`define ICLK_LOW_HZ         64000
`define ICLK_HALF(hz)       (`CLK_HZ / (2 * (hz)))

// ----------------------------------------------------------------
// External clock nominal rates, kHz
// ----------------------------------------------------------------
`define XCLK_HIGH_KHZ       13'h0800
`define XCLK_REF_KHZ        13'h0DFB
`define XCLK_LOW_KHZ        13'h1800

`endif

// ===== verilog/tri_level_sel.v
// Purpose: Registers one three-level select input as a two bit code
// Assumes: Pin level comes as two comparator bits, synchronous to core_clk
// Notes:   High wins when both bits are set
`timescale 1ns/1ns
`default_nettype none
`include "loopback_tone_consts.vh"

module tri_level_sel (
	// Clock and reset
	input  wire       core_clk,
	input  wire       rst,
	// Comparator bits
	input  wire       lvl_hi,
	input  wire       lvl_lo,
	// Registered code
	output reg  [1:0] sel_r
);

	reg [1:0] sel_nxt;

	always @* begin
		if (lvl_hi) begin
			sel_nxt = `SEL_HIGH;
		end else if (lvl_lo) begin
			sel_nxt = `SEL_LOW;
		end else begin
			sel_nxt = `SEL_REF;
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sel_r <= `SEL_REF;
		end else begin
			sel_r <= sel_nxt;
		end
	end

endmodule
`default_nettype wire

// ===== verilog/loopback_tone_detect_control.v
// Purpose: Loopback command tone qualification and loopback control
// Assumes: Front end reports tone presence, frequency and levels each cycle
// Notes:   Times counted in 1 ms ticks of core_clk
`timescale 1ns/1ns
`default_nettype none
`include "loopback_tone_consts.vh"

module loopback_tone_detect_control #(
	parameter MS_TICK_CYCLES = `MS_TICK_CYCLES
) (
	// Clock and reset
	input  wire        core_clk,
	input  wire        rst,
	// Tone front end
	input  wire        tone_present,
	input  wire [11:0] tone_freq_hz,
	input  wire [7:0]  tone_level_dbm,
	input  wire [7:0]  guard_level_dbm,
	// Three-level selects
	input  wire        timeout_period_select_hi,
	input  wire        timeout_period_select_lo,
	input  wire        internal_clock_select_hi,
	input  wire        internal_clock_select_lo,
	input  wire        external_clock_freq_select_hi,
	input  wire        external_clock_freq_select_lo,
	input  wire        timeout_or_manual_mode_hi,
	input  wire        timeout_or_manual_mode_lo,
	// Outputs
	output reg         tone_detect_n,
	output reg         loopback_active_n,
	output reg         internal_clock_monitor,
	output reg  [12:0] ext_clock_nominal_khz
);

	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	localparam [6:0] ST_IDLE      = 7'h01;
	localparam [6:0] ST_ACT_QUAL  = 7'h02;
	localparam [6:0] ST_ACT_WAIT  = 7'h04;
	localparam [6:0] ST_ACTIVE    = 7'h08;
	localparam [6:0] ST_REST_QUAL = 7'h10;
	localparam [6:0] ST_REST_WAIT = 7'h20;
	localparam [6:0] ST_MANUAL    = 7'h40;

	// Integer forms, cut to counter width below
	localparam integer TICK_LAST_I      = MS_TICK_CYCLES - 1;
	localparam integer HALF_TEST_I      = `ICLK_HALF(`ICLK_TEST_HZ);
	localparam integer HALF_REF_I       = `ICLK_HALF(`ICLK_REF_HZ);
	localparam integer HALF_LOW_SHORT_I = `ICLK_HALF(`ICLK_LOW_SHORT_HZ);
	localparam integer HALF_LOW_I       = `ICLK_HALF(`ICLK_LOW_HZ);

	localparam [14:0] TICK_LAST      = TICK_LAST_I[14:0];
	localparam [11:0] HALF_TEST      = HALF_TEST_I[11:0];
	localparam [11:0] HALF_REF       = HALF_REF_I[11:0];
	localparam [11:0] HALF_LOW_SHORT = HALF_LOW_SHORT_I[11:0];
	localparam [11:0] HALF_LOW       = HALF_LOW_I[11:0];

	// ----------------------------------------------------------------
	// Select decoding
	// ----------------------------------------------------------------
	wire [3:0] sel_hi;
	wire [3:0] sel_lo;
	wire [7:0] sel_codes;
	wire [1:0] timeout_sel;
	wire [1:0] iclk_sel;
	wire [1:0] xclk_sel;
	wire [1:0] mode_sel;

	assign sel_hi = {timeout_or_manual_mode_hi, external_clock_freq_select_hi,
		internal_clock_select_hi, timeout_period_select_hi};
	assign sel_lo = {timeout_or_manual_mode_lo, external_clock_freq_select_lo,
		internal_clock_select_lo, timeout_period_select_lo};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_sel
			tri_level_sel u_sel (
				.core_clk (core_clk),
				.rst      (rst),
				.lvl_hi   (sel_hi[gi]),
				.lvl_lo   (sel_lo[gi]),
				.sel_r    (sel_codes[2*gi+1:2*gi])
			);
		end
	endgenerate

	assign timeout_sel = sel_codes[1:0];
	assign iclk_sel    = sel_codes[3:2];
	assign xclk_sel    = sel_codes[5:4];
	assign mode_sel    = sel_codes[7:6];

	// ----------------------------------------------------------------
	// Tone qualification
	// ----------------------------------------------------------------
	wire signed [8:0] lvl_s;
	wire signed [8:0] guard_s;
	wire signed [8:0] margin_s;
	wire              freq_ok;
	wire              freq_bad;
	wire              level_ok;
	wire              guard_ok;
	wire              tone_ok;
	reg               tone_r;

	assign lvl_s    = {tone_level_dbm[7], tone_level_dbm};
	assign guard_s  = {guard_level_dbm[7], guard_level_dbm};
	assign margin_s = lvl_s - guard_s;
	assign freq_ok  = (tone_freq_hz >= `ACCEPT_LO_HZ) &&
		(tone_freq_hz <= `ACCEPT_HI_HZ);
	assign freq_bad = (tone_freq_hz < `REJECT_LO_HZ) ||
		(tone_freq_hz > `REJECT_HI_HZ);
	assign level_ok = (lvl_s >= `LEVEL_MIN_DBM) && (lvl_s <= `LEVEL_MAX_DBM) &&
		(lvl_s >= `LEVEL_REJECT_DBM);
	assign guard_ok = (margin_s >= `GUARD_MARGIN_DB);
	assign tone_ok  = tone_present & freq_ok & ~freq_bad & level_ok & guard_ok;

	// ----------------------------------------------------------------
	// Millisecond tick and gap counter
	// ----------------------------------------------------------------
	reg [14:0] tick_cnt_r;
	reg        ms_tick_r;
	reg [7:0]  gap_ms_r;
	wire       gap_early;
	wire       gap_late;

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tick_cnt_r <= 15'h0000;
			ms_tick_r  <= 1'b0;
			tone_r     <= 1'b0;
			gap_ms_r   <= 8'h00;
		end else begin
			tone_r <= tone_ok;
			if (tick_cnt_r == TICK_LAST) begin
				tick_cnt_r <= 15'h0000;
				ms_tick_r  <= 1'b1;
			end else begin
				tick_cnt_r <= tick_cnt_r + 15'h0001;
				ms_tick_r  <= 1'b0;
			end
			if (tone_r) begin
				gap_ms_r <= 8'h00;
			end else if (ms_tick_r && gap_ms_r != 8'hFF) begin
				gap_ms_r <= gap_ms_r + 8'h01;
			end
		end
	end

	assign gap_early = (gap_ms_r >= `GAP_EARLY_MS);
	assign gap_late  = (gap_ms_r >= `GAP_LATE_MS);

	// ----------------------------------------------------------------
	// Fail-safe timeout limit
	// ----------------------------------------------------------------
	reg [20:0] timeout_limit;

	always @* begin
		case (timeout_sel)
			`SEL_HIGH: timeout_limit = `TIMEOUT_SHORT_MS;
			`SEL_LOW:  timeout_limit = `TIMEOUT_LONG_MS;
			default:   timeout_limit = `TIMEOUT_MID_MS;
		endcase
	end

	// ----------------------------------------------------------------
	// Control state machine
	// ----------------------------------------------------------------
	reg [6:0]  state_r;
	reg [6:0]  state_nxt;
	reg [10:0] run_ms_r;
	reg [20:0] to_ms_r;
	reg        run_clr;
	reg        to_clr;
	wire       timeout_hit;

	assign timeout_hit = (mode_sel == `SEL_LOW) && (to_ms_r >= timeout_limit);

	always @* begin
		state_nxt = state_r;
		run_clr   = 1'b0;
		to_clr    = 1'b0;
		case (state_r)
			ST_IDLE: begin
				run_clr = 1'b1;
				if (mode_sel == `SEL_HIGH) begin
					state_nxt = ST_MANUAL;
				end else if (tone_r) begin
					state_nxt = ST_ACT_QUAL;
				end
			end
			ST_ACT_QUAL: begin
				if (mode_sel == `SEL_HIGH) begin
					state_nxt = ST_MANUAL;
				end else if (gap_early) begin
					state_nxt = ST_IDLE;
				end else if (run_ms_r >= `ACT_QUAL_MS) begin
					state_nxt = ST_ACT_WAIT;
				end
			end
			ST_ACT_WAIT: begin
				if (gap_late) begin
					state_nxt = ST_ACTIVE;
					to_clr    = 1'b1;
				end
			end
			ST_ACTIVE: begin
				run_clr = 1'b1;
				if (timeout_hit) begin
					state_nxt = ST_IDLE;
				end else if (tone_r) begin
					state_nxt = ST_REST_QUAL;
				end
			end
			ST_REST_QUAL: begin
				if (timeout_hit) begin
					state_nxt = ST_IDLE;
				end else if (gap_early) begin
					state_nxt = ST_ACTIVE;
				end else if (run_ms_r >= `REST_QUAL_MS) begin
					state_nxt = ST_REST_WAIT;
				end
			end
			ST_REST_WAIT: begin
				if (gap_late) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_MANUAL: begin
				if (mode_sel != `SEL_HIGH) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_r  <= ST_IDLE;
			run_ms_r <= 11'h000;
			to_ms_r  <= 21'h000000;
		end else begin
			state_r <= state_nxt;
			if (run_clr) begin
				run_ms_r <= 11'h000;
			end else if (ms_tick_r && run_ms_r != 11'h7FF) begin
				run_ms_r <= run_ms_r + 11'h001;
			end
			if (to_clr) begin
				to_ms_r <= 21'h000000;
			end else if (ms_tick_r && to_ms_r != 21'h1FFFFF) begin
				to_ms_r <= to_ms_r + 21'h000001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Pin outputs
	// ----------------------------------------------------------------
	reg [11:0] iclk_half;
	reg [11:0] iclk_cnt_r;

	always @* begin
		case (iclk_sel)
			`SEL_HIGH: iclk_half = HALF_TEST;
			`SEL_REF:  iclk_half = HALF_REF;
			default: begin
				if (timeout_sel == `SEL_HIGH) begin
					iclk_half = HALF_LOW_SHORT;
				end else begin
					iclk_half = HALF_LOW;
				end
			end
		endcase
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tone_detect_n          <= 1'b1;
			loopback_active_n      <= 1'b1;
			internal_clock_monitor <= 1'b0;
			iclk_cnt_r             <= 12'h000;
			ext_clock_nominal_khz  <= `XCLK_REF_KHZ;
		end else begin
			tone_detect_n     <= ~(tone_r & (state_r != ST_MANUAL) &
				(mode_sel != `SEL_HIGH));
			loopback_active_n <= ~(state_r == ST_ACTIVE || state_r == ST_REST_QUAL ||
				state_r == ST_MANUAL);
			if (iclk_cnt_r + 12'h001 >= iclk_half) begin
				iclk_cnt_r             <= 12'h000;
				internal_clock_monitor <= ~internal_clock_monitor;
			end else begin
				iclk_cnt_r <= iclk_cnt_r + 12'h001;
			end
			case (xclk_sel)
				`SEL_HIGH: ext_clock_nominal_khz <= `XCLK_HIGH_KHZ;
				`SEL_LOW:  ext_clock_nominal_khz <= `XCLK_LOW_KHZ;
				default:   ext_clock_nominal_khz <= `XCLK_REF_KHZ;
			endcase
		end
	end

endmodule
`default_nettype wire

// ===== test/loopback_tone_detect_control_checker.sv
// Purpose: Port checks for loopback tone detect and control
// Assumes: Bound to the design top with its tick parameter
// Notes:   Helper counters track level runs and monitor half periods
`timescale 1ns/1ns
`default_nettype none
module loopback_tone_detect_control_checker #(
	parameter int MS_TICK_CYCLES = 20000
) (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        rst,
	// Tone front end
	input wire logic        tone_present,
	input wire logic [11:0] tone_freq_hz,
	input wire logic [7:0]  tone_level_dbm,
	input wire logic [7:0]  guard_level_dbm,
	// Selects
	input wire logic        timeout_period_select_hi,
	input wire logic        internal_clock_select_hi,
	input wire logic        internal_clock_select_lo,
	input wire logic        external_clock_freq_select_hi,
	input wire logic        external_clock_freq_select_lo,
	input wire logic        timeout_or_manual_mode_hi,
	input wire logic        timeout_or_manual_mode_lo,
	// Outputs
	input wire logic        tone_detect_n,
	input wire logic        loopback_active_n,
	input wire logic        internal_clock_monitor,
	input wire logic [12:0] ext_clock_nominal_khz
);
	logic        ok;
	logic        mon_r;
	logic [7:0]  man_r;
	logic [1:0]  dirty_r;
	logic [11:0] half, half_r, run_r;
	logic [12:0] ek, ek1_r, ek2_r;
	int          lvl, hi_r, lo_r;
	assign lvl = int'($signed(tone_level_dbm));
	assign ok = tone_present && tone_freq_hz >= 12'hA8D && tone_freq_hz <= 12'hAA5 && lvl <= 0
		&& lvl >= -33 && lvl - int'($signed(guard_level_dbm)) >= 12;
	assign ek = external_clock_freq_select_hi ? 13'h0800
		: external_clock_freq_select_lo ? 13'h1800 : 13'h0DFB;
	assign half = internal_clock_select_hi ? 12'h9C4 : !internal_clock_select_lo ? 12'h140
		: timeout_period_select_hi ? 12'h271 : 12'h09C;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mon_r <= 1'b0;
			man_r <= 8'h00;
			ek1_r <= 13'h0DFB;
			ek2_r <= 13'h0DFB;
			half_r <= 12'h000;
			hi_r <= 0;
			lo_r <= 0;
			run_r <= 12'h000;
			dirty_r <= 2'h2;
		end else begin
			mon_r <= internal_clock_monitor;
			man_r <= {man_r[6:0], timeout_or_manual_mode_hi};
			ek1_r <= ek;
			ek2_r <= ek1_r;
			half_r <= half;
			hi_r <= tone_detect_n ? hi_r + 1 : 0;
			lo_r <= tone_detect_n ? 0 : lo_r + 1;
			run_r <= (internal_clock_monitor != mon_r) ? 12'h001 : run_r + 12'h001;
			if (half != half_r)
				dirty_r <= 2'h2;
			else if (internal_clock_monitor != mon_r && dirty_r != 2'h0)
				dirty_r <= dirty_r - 2'h1;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_auto;
		!timeout_or_manual_mode_hi [*2];
	endsequence
	sequence s_manual;
		timeout_or_manual_mode_hi [*4];
	endsequence
	a_detect_fall: assert property (
		man_r[1:0] == 2'h0 && ok && !timeout_or_manual_mode_hi ##1 s_auto |-> !tone_detect_n)
		else $error("tone detect late");
	a_detect_rise: assert property (
		!ok |-> ##2 tone_detect_n)
		else $error("tone detect without a good tone");
	a_manual_quiet: assert property (
		s_manual |-> tone_detect_n)
		else $error("tone detect in manual mode");
	a_activate_gap: assert property (
		$fell(loopback_active_n) && man_r == 8'h00 && !timeout_or_manual_mode_hi
		|-> hi_r >= 199 * MS_TICK_CYCLES)
		else $error("loopback started before tone removal");
	a_restore_run: assert property (
		$rose(loopback_active_n) && man_r == 8'h00 && !timeout_or_manual_mode_lo
		|-> lo_r >= 998 * MS_TICK_CYCLES)
		else $error("loopback ended without restoral tone");
	a_ext_clock: assert property (
		ek1_r == ek2_r |-> ext_clock_nominal_khz == ek2_r)
		else $error("external clock rate wrong");
	a_monitor_half: assert property (
		internal_clock_monitor != mon_r && dirty_r == 2'h0 |-> run_r == half_r)
		else $error("monitor half period wrong");
	a_reset_idle: assert property (
		disable iff (1'b0) rst |-> tone_detect_n && loopback_active_n && !internal_clock_monitor)
		else $error("outputs not idle in reset");
endmodule
bind loopback_tone_detect_control loopback_tone_detect_control_checker #(
	.MS_TICK_CYCLES(MS_TICK_CYCLES)
) u_checker (
	.core_clk, .rst, .tone_present, .tone_freq_hz, .tone_level_dbm, .guard_level_dbm,
	.timeout_period_select_hi, .internal_clock_select_hi, .internal_clock_select_lo,
	.external_clock_freq_select_hi, .external_clock_freq_select_lo,
	.timeout_or_manual_mode_hi, .timeout_or_manual_mode_lo, .tone_detect_n, .loopback_active_n,
	.internal_clock_monitor, .ext_clock_nominal_khz
);
`default_nettype wire

// ===== test/tone_line_model.sv
// Purpose: Line tone source and loopback relay facing the block
// Assumes: Requests change at the falling edge of core_clk
// Notes:   Without a tone the measurement lines wander every cycle
`timescale 1ns/1ns
`default_nettype none
module tone_line_model (
	// Clock
	input  wire logic        core_clk,
	// Requests
	input  wire logic        tone_on,
	input  wire logic [11:0] req_freq,
	input  wire logic [7:0]  req_lvl,
	input  wire logic [7:0]  req_guard,
	// Line
	output logic             tone_present,
	output logic [11:0]      tone_freq_hz,
	output logic [7:0]       tone_level_dbm,
	output logic [7:0]       guard_level_dbm,
	// Relay
	input  wire logic        loopback_active_n,
	output logic             relay_closed
);
	logic [11:0] junk_r = 12'h000;
	always @(negedge core_clk)
		junk_r <= junk_r + 12'h5A3;
	assign tone_present = tone_on;
	assign tone_freq_hz = tone_on ? req_freq : junk_r;
	assign tone_level_dbm = tone_on ? req_lvl : junk_r[7:0];
	assign guard_level_dbm = tone_on ? req_guard : ~junk_r[7:0];
	// Relay pulls in on the low level
	assign relay_closed = !loopback_active_n;
endmodule
`default_nettype wire

// ===== test/loopback_tone_detect_control_tb_top.sv
// Purpose: Self-checking bench for loopback tone detect and control
// Assumes: One ms is shortened to MS core_clk cycles
// Notes:   Fail-safe timeouts are too long to run here
`timescale 1ns/1ns
`default_nettype none
`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; \
	$display("ERROR %0t: got %0h exp %0h", $time, got, exp); end end
module loopback_tone_detect_control_tb_top;
	localparam int MS = 10;
	localparam logic [1:0] HI = 2'h2, LO = 2'h1, RF = 2'h0;
	int          num_errors = 0, compares = 0;
	logic        core_clk, rst, tone_on, tone_present, relay_closed;
	logic        tone_detect_n, loopback_active_n, internal_clock_monitor;
	logic [1:0]  tsel, isel, esel, mode;
	logic [7:0]  req_lvl, req_guard, tone_level_dbm, guard_level_dbm;
	logic [11:0] req_freq, tone_freq_hz;
	logic [12:0] ext_clock_nominal_khz;
	logic [11:0] f_tab[14] = '{12'hA99, 12'hA8D, 12'hAA5, 12'hA8C, 12'hAA6, 12'hA78, 12'hABA,
		12'hA99, 12'hA99, 12'hA99, 12'hA99, 12'hA99, 12'hA99, 12'hA99};
	logic [7:0]  l_tab[14] = '{8'hF6, 8'hF6, 8'hF6, 8'hF6, 8'hF6, 8'hF6, 8'hF6, 8'hDF, 8'hDE,
		8'h00, 8'h01, 8'hD9, 8'hF6, 8'hF6};
	logic [7:0]  g_tab[14] = '{8'hD8, 8'hD8, 8'hD8, 8'hD8, 8'hD8, 8'hD8, 8'hD8, 8'hCE, 8'hCE,
		8'hEC, 8'hEC, 8'hB0, 8'hEA, 8'hEB};
	logic [13:0] det_tab = 14'b10_1101_0111_1000;
	logic [1:0]  e_tab[3] = '{HI, RF, LO};
	logic [12:0] k_tab[3] = '{13'h0800, 13'h0DFB, 13'h1800};
	logic [1:0]  i_tab[5] = '{HI, RF, LO, LO, LO};
	logic [1:0]  t_tab[5] = '{RF, RF, HI, RF, LO};
	int          h_tab[5] = '{2500, 320, 625, 156, 156};
	loopback_tone_detect_control #(
		.MS_TICK_CYCLES(MS)
	) dut (
		.core_clk, .rst, .tone_present, .tone_freq_hz, .tone_level_dbm, .guard_level_dbm,
		.timeout_period_select_hi(tsel[1]), .timeout_period_select_lo(tsel[0]),
		.internal_clock_select_hi(isel[1]), .internal_clock_select_lo(isel[0]),
		.external_clock_freq_select_hi(esel[1]), .external_clock_freq_select_lo(esel[0]),
		.timeout_or_manual_mode_hi(mode[1]), .timeout_or_manual_mode_lo(mode[0]),
		.tone_detect_n, .loopback_active_n, .internal_clock_monitor, .ext_clock_nominal_khz
	);
	tone_line_model u_line (
		.core_clk, .tone_on, .req_freq, .req_lvl, .req_guard, .tone_present, .tone_freq_hz,
		.tone_level_dbm, .guard_level_dbm, .loopback_active_n, .relay_closed
	);
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic tone(input logic on, input logic [11:0] f, input logic [7:0] l, g);
		tone_on <= on;
		req_freq <= f;
		req_lvl <= l;
		req_guard <= g;
	endtask
	task automatic half_period(output int n);
		logic m;
		m = internal_clock_monitor;
		n = 0;
		while (internal_clock_monitor === m && n < 6000) begin
			tick(1);
			n++;
		end
	endtask
	task automatic final_report;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		tick(100000);
		num_errors++;
		final_report();
	end
	initial begin
		int n;
		rst = 1'b1;
		tone(1'b0, 12'hA99, 8'hF6, 8'hD8);
		tsel = RF;
		isel = RF;
		esel = RF;
		mode = RF;
		tick(8);
		`CHECK(loopback_active_n, 1'b1)
		`CHECK(ext_clock_nominal_khz, 13'h0DFB)
		rst <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			esel <= e_tab[i];
			tick(3);
			`CHECK(ext_clock_nominal_khz, k_tab[i])
		end
		// Band, level and guard edges, each a short burst
		for (int i = 0; i < 14; i++) begin
			tone(1'b1, f_tab[i], l_tab[i], g_tab[i]);
			tick(3);
			`CHECK(tone_detect_n, det_tab[i])
			tone(1'b0, 12'hA99, 8'hF6, 8'hD8);
			tick(3);
			`CHECK(tone_detect_n, 1'b1)
		end
		tick(300 * MS);
		tone_on <= 1'b1;
		tick(1900 * MS);
		tone_on <= 1'b0;
		tick(300 * MS);
		`CHECK(loopback_active_n, 1'b1)
		tone_on <= 1'b1;
		tick(2010 * MS);
		`CHECK(loopback_active_n, 1'b1)
		`CHECK(tone_detect_n, 1'b0)
		tone_on <= 1'b0;
		tick(190 * MS);
		`CHECK(loopback_active_n, 1'b1)
		tick(15 * MS);
		`CHECK(loopback_active_n, 1'b0)
		`CHECK(relay_closed, 1'b1)
		tick(300 * MS);
		`CHECK(loopback_active_n, 1'b0)
		tone_on <= 1'b1;
		tick(900 * MS);
		`CHECK(loopback_active_n, 1'b0)
		tick(110 * MS);
		`CHECK(loopback_active_n, 1'b1)
		tone_on <= 1'b0;
		tick(300 * MS);
		mode <= HI;
		tone_on <= 1'b1;
		tick(10);
		`CHECK(loopback_active_n, 1'b0)
		`CHECK(tone_detect_n, 1'b1)
		mode <= RF;
		tone_on <= 1'b0;
		tick(4);
		`CHECK(loopback_active_n, 1'b1)
		mode <= LO;
		tick(4);
		`CHECK(loopback_active_n, 1'b1)
		for (int i = 0; i < 5; i++) begin
			isel <= i_tab[i];
			tsel <= t_tab[i];
			repeat (3) half_period(n);
			`CHECK(n, h_tab[i])
		end
		final_report();
	end
endmodule
`default_nettype wire
